// file: design/flash_buf_defs.vh
// Constants for the serial flash page buffer command block
`ifndef FLASH_BUF_DEFS_VH
`define FLASH_BUF_DEFS_VH

// Opcodes
`define OP_BUF_READ 8'hD4
`define OP_BUF_WRITE 8'h84
`define OP_BUF_PROG 8'h88
`define OP_WREN 8'h06

// Bit and byte positions within a frame
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define BYTE_OPCODE 3'h0
`define BYTE_AFTER_OP 3'h1
`define BYTE_ADDR_LAST 3'h3
`define BYTE_WR_DATA 3'h4
`define BYTE_RD_DATA 3'h5
`define BYTE_ONE 3'h1
`define BIT_ONE 3'h1

// Buffer geometry
`define BUF_ENTRIES 256
`define BUF_STEP 8'h01
`define BUF_LAST_IDX 9'h0FF

// Timing
`define SYS_CLK_MHZ 250
`define NS_PER_US 1000
`define PP_TIME_NS_DEFAULT 1000000

// Engine states
`define PS_IDLE 2'h0
`define PS_XFER 2'h1
`define PS_SETTLE 2'h2

`endif

// file: design/flash_page_buffer.v
// Page buffer read, load and program command handling behind the serial pins
`timescale 1ns/1ps
`include "flash_buf_defs.vh"

module flash_page_buffer
#(
    parameter PAGE_PROGRAM_TIME_NS = `PP_TIME_NS_DEFAULT
)
(
    input wire SYS_CLK,
    input wire RSTN,
    input wire SPI_CS_N,
    input wire SPI_SCK,
    input wire SPI_SI,
    input wire PAGE_PROTECTED,
    input wire ARRAY_WR_FAIL,
    output reg SPI_SO,
    output reg SPI_SO_OE_N,
    output reg WRITE_ENABLE_LATCH,
    output reg DEVICE_IDLE_FLAG,
    output reg PROGRAM_ERROR_FLAG,
    output reg [15:0] ARRAY_PAGE,
    output reg ARRAY_WR_STROBE,
    output reg [7:0] ARRAY_WR_INDEX,
    output reg [7:0] ARRAY_WR_DATA
);

// Engine states
localparam PS_IDLE = `PS_IDLE;
localparam PS_XFER = `PS_XFER;
localparam PS_SETTLE = `PS_SETTLE;

// Longest time rounds down to whole cycles; never below one transfer pass
localparam integer PP_RAW = (PAGE_PROGRAM_TIME_NS * `SYS_CLK_MHZ) / `NS_PER_US;
localparam integer PP_CYCLES = (PP_RAW > `BUF_ENTRIES + 1) ? PP_RAW : `BUF_ENTRIES + 1;
localparam [31:0] PP_LAST = PP_CYCLES - 1;

////////////////////////////////////////////////////////////////////////////////
// Reset release
////////////////////////////////////////////////////////////////////////////////

// Reset stages
reg rst_s1;
reg rst_n;

// Release reset through two flops, assert at once
always @(posedge SYS_CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end
    else
    begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
////////////////////////////////////////////////////////////////////////////////

// First stages, read only by second stages
reg cs_s1;
reg sck_s1;
reg si_s1;
// Second stages
reg cs_s2;
reg sck_s2;
reg si_s2;
// Delayed copies for edge finding
reg cs_s3;
reg sck_s3;

// Two flops on every pin before any logic looks at it
always @(posedge SYS_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        cs_s1 <= 1'b1;
        cs_s2 <= 1'b1;
        cs_s3 <= 1'b1;
        sck_s1 <= 1'b0;
        sck_s2 <= 1'b0;
        sck_s3 <= 1'b0;
        si_s1 <= 1'b0;
        si_s2 <= 1'b0;
    end
    else
    begin
        cs_s1 <= SPI_CS_N;
        cs_s2 <= cs_s1;
        cs_s3 <= cs_s2;
        sck_s1 <= SPI_SCK;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
        si_s1 <= SPI_SI;
        si_s2 <= si_s1;
    end
end

// Edges seen only while selected; SI and SCK share latency so SI is stable
wire selected = ~cs_s2;
wire sck_rise = selected & sck_s2 & ~sck_s3;
wire sck_fall = selected & ~sck_s2 & sck_s3;
// Frame end on chip select rise
wire cs_rise = cs_s2 & ~cs_s3;

////////////////////////////////////////////////////////////////////////////////
// Frame decoder and buffer access
////////////////////////////////////////////////////////////////////////////////

// Buffer storage, never cleared
reg [7:0] buffer_mem [0:`BUF_ENTRIES-1];
// Frame counters
reg [2:0] bit_cnt;
reg [2:0] byte_cnt;
reg [7:0] shift_in;
reg [7:0] opcode;
reg [15:0] addr_high;
// Buffer pointers
reg [7:0] rd_ptr;
reg [7:0] wr_ptr;
reg [7:0] out_byte;
// Program engine
reg [1:0] prog_state;
reg [31:0] prog_cnt;

// Byte just completed on this rising edge
wire [7:0] byte_in = {shift_in[6:0], si_s2};
wire byte_done = sck_rise & (bit_cnt == `BIT_LAST);
// No frames are served while the engine owns the buffer
wire busy = (prog_state != PS_IDLE);
wire is_read = (opcode == `OP_BUF_READ);
wire is_write = (opcode == `OP_BUF_WRITE);
wire is_prog = (opcode == `OP_BUF_PROG);
wire store_ok = is_write & WRITE_ENABLE_LATCH & ~busy;
wire on_boundary = (bit_cnt == `BIT_FIRST);

// Bit and byte counting, opcode and address capture
always @(posedge SYS_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        bit_cnt <= `BIT_FIRST;
        byte_cnt <= `BYTE_OPCODE;
        shift_in <= 8'h00;
        opcode <= 8'h00;
        addr_high <= 16'h0000;
        rd_ptr <= 8'h00;
        wr_ptr <= 8'h00;
        ARRAY_PAGE <= 16'h0000;
    end
    else if (!selected)
    begin
        // Counters restart each frame; opcode forgotten so stray edges do nothing
        bit_cnt <= `BIT_FIRST;
        byte_cnt <= `BYTE_OPCODE;
        if (cs_rise)
        begin
            opcode <= 8'h00;
        end
    end
    else if (sck_rise)
    begin
        shift_in <= byte_in;
        bit_cnt <= bit_cnt + `BIT_ONE;
        if (bit_cnt == `BIT_LAST)
        begin
            // Saturate once in the data phase
            if (byte_cnt != `BYTE_RD_DATA)
            begin
                byte_cnt <= byte_cnt + `BYTE_ONE;
            end
            if (byte_cnt == `BYTE_OPCODE)
            begin
                opcode <= byte_in;
            end
            else if (byte_cnt < `BYTE_ADDR_LAST)
            begin
                addr_high <= {addr_high[7:0], byte_in};
            end
            else if (byte_cnt == `BYTE_ADDR_LAST)
            begin
                if (is_read)
                begin
                    rd_ptr <= byte_in;
                end
                if (is_write)
                begin
                    wr_ptr <= byte_in;
                end
                if (is_prog && !busy)
                begin
                    ARRAY_PAGE <= addr_high;
                end
            end
            else if (store_ok)
            begin
                wr_ptr <= wr_ptr + `BUF_STEP;
            end
        end
    end
    else if (sck_fall && is_read && !busy && byte_cnt == `BYTE_RD_DATA && on_boundary)
    begin
        rd_ptr <= rd_ptr + `BUF_STEP;
    end
end

// Buffer store; no reset so old entries survive
always @(posedge SYS_CLK)
begin
    if (byte_done && store_ok && byte_cnt >= `BYTE_WR_DATA)
    begin
        buffer_mem[wr_ptr] <= byte_in;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial output
////////////////////////////////////////////////////////////////////////////////

// Read data changes on falling edges, pin floats between frames
always @(posedge SYS_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        SPI_SO <= 1'b0;
        SPI_SO_OE_N <= 1'b1;
        out_byte <= 8'h00;
    end
    else if (!selected)
    begin
        SPI_SO_OE_N <= 1'b1;
    end
    else if (sck_fall && is_read && !busy && byte_cnt == `BYTE_RD_DATA)
    begin
        SPI_SO_OE_N <= 1'b0;
        if (on_boundary)
        begin
            out_byte <= buffer_mem[rd_ptr];
            SPI_SO <= buffer_mem[rd_ptr][7];
        end
        else
        begin
            SPI_SO <= out_byte[`BIT_LAST - bit_cnt];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Latch, program engine and status
////////////////////////////////////////////////////////////////////////////////

// Frame end classification
wire end_valid = cs_rise & on_boundary & ~busy;
wire wren_end = end_valid & (opcode == `OP_WREN) & (byte_cnt == `BYTE_AFTER_OP);
wire prog_end = end_valid & is_prog;
wire addr_full = (byte_cnt >= `BYTE_WR_DATA);
wire prog_go = prog_end & addr_full & WRITE_ENABLE_LATCH & ~PAGE_PROTECTED;

// Engine: stream 256 entries out, then hold busy to the time limit
always @(posedge SYS_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        prog_state <= PS_IDLE;
        prog_cnt <= 32'h00000000;
        ARRAY_WR_STROBE <= 1'b0;
        ARRAY_WR_INDEX <= 8'h00;
        ARRAY_WR_DATA <= 8'h00;
    end
    else
    begin
        ARRAY_WR_STROBE <= 1'b0;
        case (prog_state)
            PS_IDLE:
            begin
                prog_cnt <= 32'h00000000;
                if (prog_go)
                begin
                    prog_state <= PS_XFER;
                end
            end
            PS_XFER:
            begin
                ARRAY_WR_STROBE <= 1'b1;
                ARRAY_WR_INDEX <= prog_cnt[7:0];
                ARRAY_WR_DATA <= buffer_mem[prog_cnt[7:0]];
                prog_cnt <= prog_cnt + 32'h00000001;
                if (prog_cnt[8:0] == `BUF_LAST_IDX)
                begin
                    prog_state <= PS_SETTLE;
                end
            end
            PS_SETTLE:
            begin
                prog_cnt <= prog_cnt + 32'h00000001;
                if (prog_cnt >= PP_LAST)
                begin
                    prog_state <= PS_IDLE;
                end
            end
            default:
            begin
                prog_state <= PS_IDLE;
            end
        endcase
    end
end

// Status bits shared with the rest of the device
always @(posedge SYS_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        WRITE_ENABLE_LATCH <= 1'b0;
        DEVICE_IDLE_FLAG <= 1'b1;
        PROGRAM_ERROR_FLAG <= 1'b0;
    end
    else
    begin
        if (wren_end)
        begin
            WRITE_ENABLE_LATCH <= 1'b1;
        end
        else if (prog_end && !addr_full)
        begin
            WRITE_ENABLE_LATCH <= 1'b0;
        end
        else if (prog_end && WRITE_ENABLE_LATCH && PAGE_PROTECTED)
        begin
            WRITE_ENABLE_LATCH <= 1'b0;
        end
        else if (prog_go)
        begin
            WRITE_ENABLE_LATCH <= 1'b0;
        end
        DEVICE_IDLE_FLAG <= ~(prog_go | (busy & ~(prog_state == PS_SETTLE && prog_cnt >= PP_LAST)));
        if (ARRAY_WR_STROBE && ARRAY_WR_FAIL)
        begin
            PROGRAM_ERROR_FLAG <= 1'b1;
        end
        else if (prog_go)
        begin
            PROGRAM_ERROR_FLAG <= 1'b0;
        end
    end
end

endmodule

// file: verification/flash_page_buffer_checker.sv
// Concurrent checks on the page buffer block's ports
`timescale 1ns/1ps
module flash_page_buffer_checker
#(
    parameter PAGE_PROGRAM_TIME_NS = 1000000
)
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic SPI_SI,
    input wire logic PAGE_PROTECTED,
    input wire logic ARRAY_WR_FAIL,
    input wire logic SPI_SO,
    input wire logic SPI_SO_OE_N,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic DEVICE_IDLE_FLAG,
    input wire logic PROGRAM_ERROR_FLAG,
    input wire logic [15:0] ARRAY_PAGE,
    input wire logic ARRAY_WR_STROBE,
    input wire logic [7:0] ARRAY_WR_INDEX,
    input wire logic [7:0] ARRAY_WR_DATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    // Deselect floats SO within the sync delay
    property p_float; $rose(SPI_CS_N) |-> ##[1:5] SPI_SO_OE_N; endproperty
    a_float: assert property (p_float) else $error("SO still driven after deselect");
    // Busy start always leaves the latch clear
    property p_wel_clr; $fell(DEVICE_IDLE_FLAG) |-> !WRITE_ENABLE_LATCH; endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch set while busy");
    property p_first; $fell(DEVICE_IDLE_FLAG) |-> ##[0:4] ARRAY_WR_STROBE && ARRAY_WR_INDEX == 8'h00; endproperty
    a_first: assert property (p_first) else $error("page not started at byte zero");
    // Array traffic only while busy
    property p_busy; ARRAY_WR_STROBE |-> !DEVICE_IDLE_FLAG; endproperty
    a_busy: assert property (p_busy) else $error("strobe while idle");
    property p_step; ARRAY_WR_STROBE && $past(ARRAY_WR_STROBE) |-> ARRAY_WR_INDEX == $past(ARRAY_WR_INDEX) + 8'h01; endproperty
    a_step: assert property (p_step) else $error("index did not step");
    property p_err; ARRAY_WR_STROBE && ARRAY_WR_FAIL |=> PROGRAM_ERROR_FLAG; endproperty
    a_err: assert property (p_err) else $error("error flag not set");
    property p_err_cause; $rose(PROGRAM_ERROR_FLAG) |-> $past(ARRAY_WR_FAIL) && $past(ARRAY_WR_STROBE); endproperty
    a_err_cause: assert property (p_err_cause) else $error("error flag without failure");
    // Latch only set once the frame has closed
    property p_wel_set; $rose(WRITE_ENABLE_LATCH) |-> SPI_CS_N && DEVICE_IDLE_FLAG; endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch set inside a frame");
    property p_page; !DEVICE_IDLE_FLAG |-> $stable(ARRAY_PAGE); endproperty
    a_page: assert property (p_page) else $error("page moved while busy");
    // Busy never outlasts the longest program time
    localparam integer PP_RAW = (PAGE_PROGRAM_TIME_NS * 250) / 1000;
    localparam integer PP_CYCLES = (PP_RAW > 257) ? PP_RAW : 257;
    int busy_cnt = 0;
    always @(posedge SYS_CLK)
        busy_cnt <= DEVICE_IDLE_FLAG ? 0 : busy_cnt + 1;
    property p_tpp; !DEVICE_IDLE_FLAG |-> busy_cnt < PP_CYCLES; endproperty
    a_tpp: assert property (p_tpp) else $error("busy beyond program time");
    c_prog: cover property ($fell(DEVICE_IDLE_FLAG));
    c_fail: cover property (ARRAY_WR_STROBE && ARRAY_WR_FAIL);
    c_read: cover property ($fell(SPI_SO_OE_N));
endmodule
bind flash_page_buffer flash_page_buffer_checker #(.PAGE_PROGRAM_TIME_NS(PAGE_PROGRAM_TIME_NS)) chk_i (.*);

// file: verification/spi_host_model.sv
// Behavioural host controller on the serial pins, mode 0
`timescale 1ns/1ps
module spi_host_model
(
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe_n,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // A floating SO reads as the inverse of its last level
    logic last_so = 1'b0;
    always @(posedge clk)
        if (!so_oe_n)
            last_so <= so;
    wire logic so_wire = so_oe_n ? ~last_so : so;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Drive on fall, sample on rise
    task bitx(input logic b, output logic r);
        sck <= 1'b0;
        si <= b;
        repeat (6) @(posedge clk);
        sck <= 1'b1;
        r = so_wire;
        repeat (6) @(posedge clk);
    endtask
    task xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
    endtask
    task opc(input logic [7:0] op);
        logic [7:0] d;
        cs_n <= 1'b0;
        repeat (6) @(posedge clk);
        xbyte(op, d);
    endtask
    // Opcode then all 24 address bits
    task cmd(input logic [7:0] op, input logic [23:0] a);
        logic [7:0] d;
        opc(op);
        for (int k = 2; k >= 0; k--)
            xbyte(a[8*k +: 8], d);
    endtask
    // Clock parked low, SI toggled once released
    task end_frame;
        sck <= 1'b0;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (6) @(posedge clk);
    endtask
endmodule

// file: verification/serial_flash_page_buffer_commands_tb.sv
// Self-checking bench for the page buffer command block
`timescale 1ns/1ps
module serial_flash_page_buffer_commands_tb;
    logic SYS_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic PAGE_PROTECTED = 1'b0;
    logic fail_en = 1'b0;
    wire cs_n, sck, si, so, so_oe_n, write_enable_latch, idle, perr, strb, fail;
    wire [15:0] page;
    wire [7:0] widx, wdat;
    int fails = 0, num_checks = 0, nstrobe = 0;
    logic [7:0] got [256];
    logic [7:0] d;
    always #2 SYS_CLK = ~SYS_CLK;
    // One byte of the page reports a failure
    assign fail = fail_en && strb && widx == 8'h10;
    flash_page_buffer #(.PAGE_PROGRAM_TIME_NS(2000)) uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .SPI_CS_N(cs_n),
        .SPI_SCK(sck), .SPI_SI(si), .PAGE_PROTECTED(PAGE_PROTECTED), .ARRAY_WR_FAIL(fail), .SPI_SO(so),
        .SPI_SO_OE_N(so_oe_n), .WRITE_ENABLE_LATCH(write_enable_latch), .DEVICE_IDLE_FLAG(idle), .PROGRAM_ERROR_FLAG(perr),
        .ARRAY_PAGE(page), .ARRAY_WR_STROBE(strb), .ARRAY_WR_INDEX(widx), .ARRAY_WR_DATA(wdat));
    spi_host_model host (.clk(SYS_CLK), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck), .si(si));
    // Record what reaches the array
    always @(posedge SYS_CLK)
        if (strb)
        begin
            got[widx] <= wdat;
            nstrobe <= nstrobe + 1;
        end
    ////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wren;
        host.opc(8'h06);
        host.end_frame();
    endtask
    task t_load;
        wren();
        chk("wel", write_enable_latch, 1'b1);
        host.cmd(8'h84, 24'h7700FE);
        for (int i = 0; i < 3; i++)
            host.xbyte(8'hA0 + i[7:0], d);
        host.end_frame();
        host.cmd(8'h84, 24'h000001);
        host.xbyte(8'h3C, d);
        host.end_frame();
        host.cmd(8'h84, 24'h000000);
        repeat (5) host.bitx(1'b0, d[0]);
        host.end_frame();
        $display("load done");
    endtask
    task t_read(input logic [7:0] e0);
        logic [7:0] e [4];
        e = '{e0, 8'hA1, 8'hA2, 8'h3C};
        host.cmd(8'hD4, 24'hABCDFE);
        host.xbyte(8'h00, d);
        for (int i = 0; i < 4; i++)
        begin
            host.xbyte(8'h00, d);
            chk("rd", d, e[i]);
        end
        chk("oe", so_oe_n, 1'b0);
        repeat (3) host.bitx(1'b0, d[0]);
        host.end_frame();
        chk("oe", so_oe_n, 1'b1);
        $display("read done");
    endtask
    task t_prog;
        int n;
        fail_en <= 1'b1;
        wren();
        host.cmd(8'h88, 24'h123456);
        host.end_frame();
        chk("idle", idle, 1'b0);
        chk("wel", write_enable_latch, 1'b0);
        chk("page", page, 16'h1234);
        n = 0;
        while (idle !== 1'b1 && n < 1000)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n >= 1000)
        begin
            fails++;
            test_done();
        end
        chk("count", nstrobe, 256);
        chk("b0", got[8'hFE], 8'hA0);
        chk("b1", got[8'h00], 8'hA2);
        chk("b2", got[8'h01], 8'h3C);
        chk("err", perr, 1'b1);
        $display("program done");
    endtask
    task t_refuse;
        PAGE_PROTECTED <= 1'b1;
        wren();
        host.cmd(8'h88, 24'h000100);
        host.end_frame();
        chk("idle", idle, 1'b1);
        chk("wel", write_enable_latch, 1'b0);
        PAGE_PROTECTED <= 1'b0;
        wren();
        host.cmd(8'h88, 24'h0);
        repeat (3) host.bitx(1'b0, d[0]);
        host.end_frame();
        chk("idle", idle, 1'b1);
        chk("wel", write_enable_latch, 1'b1);
        host.opc(8'h88);
        repeat (2) host.xbyte(8'h00, d);
        host.end_frame();
        chk("idle", idle, 1'b1);
        chk("wel", write_enable_latch, 1'b0);
        host.cmd(8'h84, 24'h0000FE);
        host.xbyte(8'h55, d);
        host.end_frame();
        host.cmd(8'hD4, 24'h0000FE);
        repeat (2) host.xbyte(8'h00, d);
        host.end_frame();
        chk("rd", d, 8'hA0);
        host.cmd(8'h88, 24'h0);
        host.end_frame();
        chk("idle", idle, 1'b1);
        $display("refuse done");
    endtask
    initial
    begin
        repeat (5) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        repeat (5) @(posedge SYS_CLK);
        chk("idle", idle, 1'b1);
        chk("oe", so_oe_n, 1'b1);
        t_load();
        t_read(8'hA0);
        t_prog();
        t_refuse();
        test_done();
    end
endmodule
